// >>> common/acdi_pkg.sv
// constants and contract list for the auto call dialer interface
// Contract
// - on the last interrupt software clears digit present and the dial enable, and no interrupt follows.
// - calling unit status is readable in line register 5 at any time.
// - a change of any selected bit of line register 5 raises a scan event.
// - call origination status at one marks the connection complete.
// - digit leads nb1, nb2, nb4, nb8 come from bits 7, 6, 5, 4 of the digit output register.
// - digit present, call request and digit leads go out; the five status lines come in.
// - with dial enable set, each edge of present next digit raises a channel request.
// - register 2 holds call request bit 1, digit present bit 2, dial enable bit 4; register 5 status.
// - when the unit drops call request the call request bit clears by itself.
// - inputs are not latched; reads return live levels, digit outputs hold until rewritten.
package acdi_pkg;
    localparam logic [4:0] ACDI_LR1_ADR = 5'h04;
    localparam logic [4:0] ACDI_LR2_ADR = 5'h08;
    localparam logic [4:0] ACDI_LR5_ADR = 5'h14;
    localparam logic [4:0] ACDI_SEL_ADR = 5'h18;
    localparam logic [4:0] ACDI_STS_ADR = 5'h00;
    localparam logic [4:0] ACDI_MSK_ADR = 5'h0c;
    localparam logic [4:0] ACDI_INI_ADR = 5'h10;
    localparam int ACDI_CRQ_BIT = 1;
    localparam int ACDI_DPR_BIT = 2;
    localparam int ACDI_DIP_BIT = 4;
    localparam int ACDI_COS_BIT = 0;
    localparam int ACDI_PWI_BIT = 1;
    localparam int ACDI_DLO_BIT = 2;
    localparam int ACDI_ACR_BIT = 3;
    localparam int ACDI_PND_BIT = 4;
    localparam int ACDI_ST_CHREQ = 0;
    localparam int ACDI_ST_SCAN = 1;
    localparam logic [7:0] ACDI_RST_BYTE = 8'h00;
endpackage : acdi_pkg

// >>> test/acdi_acu_model.sv
// behavioural calling unit for the dialer bench
`timescale 1ns/100ps
module acdi_acu_model #(
    parameter int DLY = 3
) (
    input wire logic clk_i,
    input wire logic crq_i,
    input wire logic dpr_i,
    input wire logic cos_i,
    input wire logic acr_i,
    output logic pnd_o,
    output logic cos_o,
    output logic acr_o,
    output logic pwi_o,
    output logic dlo_o
);
    int cnt_r = 0;
    initial pnd_o = 1'b0;
    assign pwi_o = 1'b1;
    assign dlo_o = 1'b0;
    assign cos_o = cos_i;
    assign acr_o = acr_i;
    // next digit handshake
    // slow on purpose: each edge lags its cause by DLY+1 cycles
    always @(posedge clk_i) begin
        if (pnd_o == (crq_i && !dpr_i)) cnt_r <= 0;
        else if (cnt_r == DLY) pnd_o <= crq_i && !dpr_i;
        else cnt_r <= cnt_r + 1;
    end
endmodule : acdi_acu_model

// >>> test/acdi_top_test.sv
// self-checking bench for the dialer line interface
`timescale 1ns/100ps
module acdi_top_test import acdi_pkg::*;;
    logic clk_i = 0, rst_i = 1, cyc_r = 0, we_r = 0, cos_r = 0, acr_r = 0;
    logic [4:0] adr_r = 0;
    logic [31:0] dat_r = 0, seed = 32'h922a, wb_dat_o;
    logic wb_ack_o, irq_o, dpr_o, crq_o, nb1_o, nb2_o, nb4_o, nb8_o, pnd, cos, acr, pwi, dlo;
    logic [31:0] exp_q[$];
    logic [7:0] lr2_v[5] = '{8'h12, 8'h16, 8'h12, 8'h06, 8'h02};
    logic [4:0] irq_v = 5'b00111;
    int n_fail = 0, num_checks = 0, cyc_n = 0, i;
    always #50 clk_i = ~clk_i;
    acdi_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc_r), .wb_stb_i(cyc_r),
        .wb_we_i(we_r), .wb_adr_i(adr_r), .wb_sel_i(4'h1), .wb_dat_i(dat_r),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .dpr_o(dpr_o),
        .crq_o(crq_o), .nb1_o(nb1_o), .nb2_o(nb2_o), .nb4_o(nb4_o), .nb8_o(nb8_o),
        .acr_i(acr), .pnd_i(pnd), .pwi_i(pwi), .cos_i(cos), .dlo_i(dlo));
    acdi_acu_model acu (.clk_i(clk_i), .crq_i(crq_o), .dpr_i(dpr_o), .cos_i(cos_r),
        .acr_i(acr_r), .pnd_o(pnd), .cos_o(cos), .acr_o(acr), .pwi_o(pwi), .dlo_o(dlo));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done
    task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc_r <= 1'b1;
        we_r <= we;
        adr_r <= a;
        dat_r <= d;
        // no assumed latency; only the cycle ceiling ends a hung wait
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        cyc_r <= 1'b0;
    endtask : wb
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask : rd
    // read data taken at the edge that samples ack high
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && we_r === 1'b0) chk(wb_dat_o, exp_q.pop_front(), "read");
    end
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 3000) begin
            n_fail++;
            test_done();
        end
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(ACDI_LR2_ADR, 32'h0);
        rd(ACDI_STS_ADR, 32'h0);
        chk({31'h0, crq_o}, 32'h0, "crq");
        wb(1'b1, ACDI_SEL_ADR, 32'h0);
        wb(1'b1, ACDI_MSK_ADR, 32'h3);
        for (i = 0; i < 2; i++) begin
            seed = lfsr(seed);
            wb(1'b1, ACDI_LR1_ADR, {24'h0, seed[7:0]});
            chk({28'h0, nb1_o, nb2_o, nb4_o, nb8_o}, {28'h0, seed[7:4]}, "digit");
            rd(ACDI_LR1_ADR, {24'h0, seed[7:0]});
        end
        // edges raise requests only while dialing is enabled
        for (i = 0; i < 5; i++) begin
            // crq kept throughout, dip dropped in step 3, dpr dropped last
            wb(1'b1, ACDI_LR2_ADR, {24'h0, lr2_v[i]});
            chk({30'h0, dpr_o, crq_o}, {30'h0, lr2_v[i][2:1]}, "lr2 pins");
            repeat (10) @(posedge clk_i);
            chk({31'h0, irq_o}, {31'h0, irq_v[i]}, "irq");
            rd(ACDI_STS_ADR, {31'h0, irq_v[i]});
            wb(1'b1, ACDI_STS_ADR, 32'h1);
        end
        wb(1'b1, ACDI_SEL_ADR, 32'h1);
        @(posedge clk_i);
        cos_r <= 1'b1;
        acr_r <= 1'b1;
        repeat (6) @(posedge clk_i);
        rd(ACDI_LR5_ADR, {27'h0, pnd, 4'b1011});
        rd(ACDI_STS_ADR, 32'h2);
        wb(1'b1, ACDI_STS_ADR, 32'h2);
        // crq falls only after cos, no abort race
        @(posedge clk_i);
        cos_r <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk({31'h0, crq_o}, 32'h0, "crq drop");
        rd(ACDI_LR2_ADR, 32'h0);
        rd(5'h1c, 32'h0);
        wb(1'b1, 5'h1c, 32'hff);
        wb(1'b1, ACDI_LR1_ADR, 32'ha5);
        wb(1'b1, ACDI_INI_ADR, 32'h1);
        rd(ACDI_LR1_ADR, 32'h0);
        rd(ACDI_STS_ADR, 32'h0);
        chk({31'h0, irq_o}, 32'h0, "irq init");
        test_done();
    end
endmodule : acdi_top_test

// >>> verilog/acdi_edge.sv
`timescale 1ns/100ps
// previous-value register and change detector for a status vector
module acdi_edge #(
    parameter int W = 5
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] chg_o
);
    logic [W-1:0] prev_r;
    logic [W-1:0] chg_r;
    logic prime_r;
    // first sample after reset only fills the history; idle-high pins give no false edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_r <= '0;
            chg_r <= '0;
            prime_r <= 1'b0;
        end else begin
            prev_r <= d_i;
            chg_r <= prime_r ? (d_i ^ prev_r) : '0;
            prime_r <= 1'b1;
        end
    end
    assign chg_o = chg_r;
endmodule : acdi_edge

// >>> verilog/acdi_top.sv
`timescale 1ns/100ps
// dialer line interface with wishbone registers
module acdi_top
    import acdi_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    output logic dpr_o,
    output logic crq_o,
    output logic nb1_o,
    output logic nb2_o,
    output logic nb4_o,
    output logic nb8_o,
    input wire logic acr_i,
    input wire logic pnd_i,
    input wire logic pwi_i,
    input wire logic cos_i,
    input wire logic dlo_i
);
    logic [7:0] digit_output_register_r;
    logic [7:0] lr2_r;
    logic [4:0] sel_r;
    logic [1:0] sts_r;
    logic [1:0] msk_r;
    logic ack_r;
    logic [31:0] dat_r;
    logic irq_r;
    logic crq_in_prev_r;
    logic [4:0] live;
    logic [4:0] chg;
    logic acc;
    logic wr;
    logic wr_lr1;
    logic wr_lr2;
    logic wr_sts;
    logic wr_msk;
    logic wr_sel;
    logic chinit;
    logic chreq_ev;
    logic scan_ev;
    logic crq_drop;
    logic [31:0] rd_mux;
    logic hit;
    logic [1:0] sts_nxt;
    logic [7:0] lr2_nxt;

    // live status, never latched
    // live status read
    assign live = {pnd_i, acr_i, dlo_i, pwi_i, cos_i};

    acdi_edge #(.W(5)) u_edge (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(live),
        .chg_o(chg)
    );

    assign acc = wb_cyc_i && wb_stb_i && !ack_r;
    assign wr = acc && wb_we_i && wb_sel_i[0];
    assign wr_lr1 = wr && (wb_adr_i == ACDI_LR1_ADR);
    assign wr_lr2 = wr && (wb_adr_i == ACDI_LR2_ADR);
    assign wr_sts = wr && (wb_adr_i == ACDI_STS_ADR);
    assign wr_msk = wr && (wb_adr_i == ACDI_MSK_ADR);
    assign wr_sel = wr && (wb_adr_i == ACDI_SEL_ADR);
    assign chinit = wr && (wb_adr_i == ACDI_INI_ADR) && wb_dat_i[0];

    assign chreq_ev = chg[ACDI_PND_BIT] && lr2_r[ACDI_DIP_BIT];
    assign scan_ev = |(chg & sel_r);
    // unit dropped call request; sensed as origination status falling during a call
    assign crq_drop = crq_in_prev_r && !cos_i && lr2_r[ACDI_CRQ_BIT];

    // set wins over write-one clear
    assign sts_nxt = (sts_r & ~(wr_sts ? wb_dat_i[1:0] : 2'b00)) | {scan_ev, chreq_ev};

    assign lr2_nxt = wr_lr2 ? wb_dat_i[7:0] :
        (crq_drop ? (lr2_r & ~(8'h01 << ACDI_CRQ_BIT)) : lr2_r);

    assign hit = (wb_adr_i == ACDI_LR1_ADR) || (wb_adr_i == ACDI_LR2_ADR) ||
        (wb_adr_i == ACDI_LR5_ADR) || (wb_adr_i == ACDI_STS_ADR) ||
        (wb_adr_i == ACDI_MSK_ADR) || (wb_adr_i == ACDI_SEL_ADR) ||
        (wb_adr_i == ACDI_INI_ADR);

    assign rd_mux = (wb_adr_i == ACDI_LR1_ADR) ? {24'h000000, digit_output_register_r} :
        (wb_adr_i == ACDI_LR2_ADR) ? {24'h000000, lr2_r} :
        (wb_adr_i == ACDI_LR5_ADR) ? {27'h0, live} :
        (wb_adr_i == ACDI_STS_ADR) ? {30'h0, sts_r} :
        (wb_adr_i == ACDI_MSK_ADR) ? {30'h0, msk_r} :
        (wb_adr_i == ACDI_SEL_ADR) ? {27'h0, sel_r} : 32'h00000000;

    // unmapped reads return zero, writes ignored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h00000000;
        end else begin
            ack_r <= acc;
            dat_r <= (acc && hit) ? rd_mux : 32'h00000000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || chinit) begin
            digit_output_register_r <= ACDI_RST_BYTE;
            lr2_r <= ACDI_RST_BYTE;
            sts_r <= 2'b00;
        end else begin
            if (wr_lr1) begin
                digit_output_register_r <= wb_dat_i[7:0];
            end
            lr2_r <= lr2_nxt;
            sts_r <= sts_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            msk_r <= 2'b00;
            sel_r <= 5'h00;
            crq_in_prev_r <= 1'b0;
        end else begin
            if (wr_msk) begin
                msk_r <= wb_dat_i[1:0];
            end
            if (wr_sel) begin
                sel_r <= wb_dat_i[4:0];
            end
            crq_in_prev_r <= cos_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(sts_nxt & msk_r) && !chinit;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign irq_o = irq_r;
    assign nb1_o = digit_output_register_r[7];
    assign nb2_o = digit_output_register_r[6];
    assign nb4_o = digit_output_register_r[5];
    assign nb8_o = digit_output_register_r[4];
    assign crq_o = lr2_r[ACDI_CRQ_BIT];
    assign dpr_o = lr2_r[ACDI_DPR_BIT];

    // request only with enable set
    property p_chreq_needs_dip;
        @(posedge clk_i) disable iff (rst_i)
        (chg[ACDI_PND_BIT] && !lr2_r[ACDI_DIP_BIT] && !chinit && !(wr_sts && wb_dat_i[0]))
            |=> (sts_r[ACDI_ST_CHREQ] == $past(sts_r[ACDI_ST_CHREQ]));
    endproperty
    a_chreq_needs_dip: assert property (p_chreq_needs_dip) else $error("request without enable");

    property p_pnd_edge_req;
        @(posedge clk_i) disable iff (rst_i)
        ($changed(pnd_i) && lr2_r[ACDI_DIP_BIT] && !wr_lr2 && !chinit) ##1 !chinit
            |=> sts_r[ACDI_ST_CHREQ];
    endproperty
    a_pnd_edge_req: assert property (p_pnd_edge_req) else $error("pnd edge lost");

    property p_lr5_live;
        @(posedge clk_i) disable iff (rst_i)
        (acc && !wb_we_i && wb_adr_i == ACDI_LR5_ADR) |=> (wb_dat_o[4:0] == $past(live));
    endproperty
    a_lr5_live: assert property (p_lr5_live) else $error("status not live");

    property p_scan;
        @(posedge clk_i) disable iff (rst_i)
        (|(chg & sel_r) && !chinit) |=> sts_r[ACDI_ST_SCAN];
    endproperty
    a_scan: assert property (p_scan) else $error("scan event lost");

    property p_digit;
        @(posedge clk_i) disable iff (rst_i)
        wr_lr1 && !chinit |=> ({nb8_o, nb4_o, nb2_o, nb1_o} == {$past(wb_dat_i[4]),
            $past(wb_dat_i[5]), $past(wb_dat_i[6]), $past(wb_dat_i[7])});
    endproperty
    a_digit: assert property (p_digit) else $error("digit leads wrong");

    property p_crq_drop;
        @(posedge clk_i) disable iff (rst_i)
        (crq_drop && !wr_lr2) |=> !crq_o;
    endproperty
    a_crq_drop: assert property (p_crq_drop) else $error("crq not cleared");

    property p_hold;
        @(posedge clk_i) disable iff (rst_i)
        (!wr_lr1 && !chinit) |=> $stable(digit_output_register_r);
    endproperty
    a_hold: assert property (p_hold) else $error("outputs not held");

    property p_init;
        @(posedge clk_i) disable iff (rst_i)
        chinit |=> (!crq_o && !dpr_o && !lr2_r[ACDI_DIP_BIT] && !irq_o) [*1];
    endproperty
    a_init: assert property (p_init) else $error("init left state");

    property p_ack;
        @(posedge clk_i) disable iff (rst_i)
        acc |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack not one cycle");
endmodule : acdi_top
